//--- hdl/brc_pkg.sv
package brc_pkg;
	localparam logic [15:0] BRC_CFG_OFFSET = 16'h101C;
	localparam logic [15:0] BRC_CFG_RESET = 16'h0000;
	localparam logic [15:0] BRC_CFG_WMASK = 16'hFF07;
	localparam int BRC_EN_BIT = 0;
	localparam int BRC_INV_BIT = 1;
	localparam int BRC_HOLD_BIT = 2;
	localparam int BRC_LAT_LSB = 8;
	localparam int BRC_LEN_LSB = 12;
	localparam logic [3:0] BRC_LAT_BASE = 4'h2;
	localparam logic [3:0] BRC_LEN_MAX = 4'hA;
	localparam int BRC_CLK_NS = 40;
	localparam int BRC_LINK_NS = 320;
	localparam int BRC_HALF_LINK_CYC = (BRC_LINK_NS / 2 + BRC_CLK_NS - 1) / BRC_CLK_NS;

	typedef struct packed {
		logic [3:0] burstLength;
		logic [3:0] latency;
		logic [4:0] reservedZero;
		logic hold;
		logic sampleEdgeInvert;
		logic burstEnable;
	} brc_cfg_t;

	typedef struct packed {
		logic chipEnN;
		logic outEnN;
		logic busWide;
	} brc_pins_t;

	typedef enum logic [3:0] {
		BRC_IDLE = 4'b0001,
		BRC_LAT = 4'b0010,
		BRC_DATA = 4'b0100,
		BRC_DONE = 4'b1000
	} brc_state_t;
endpackage : brc_pkg

//--- hdl/brc_mem.sv
`timescale 1ns/10ps
module brc_mem
	import brc_pkg::*;
#(
	parameter int AW = 12,
	parameter int DW = 16
) (
	input wire logic mclk,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic wrEn,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData_q
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Read data registered for timing
	always_ff @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData_q <= mem[rdAddr];
	end
endmodule : brc_mem

//--- hdl/brc_burst_read_control.sv
`timescale 1ns/10ps
// Function
// - Burst disabled: link clock ignored, may float, no burst cycles.
// - Invert clear: enables sampled on rising link clock edge.
// - Invert set: sampled on falling edge, half clock extra delay.
// - Each word held one clock, or two when hold bit set.
// - First word latchable two plus latency clocks after enables sampled.
// - Hold set: first word valid on latency clock and next one.
// - Hold clear: burst transfers two to the length units.
// - Hold set: burst transfers two to length minus one units.
// - Bits three to seven reserved: read zero, not writable.
// - Units are bytes when bus width input low, words when high.
module brc_burst_read_control
	import brc_pkg::*;
#(
	parameter int AW = 12
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData_q,
	input wire logic [AW-1:0] memWrAddr,
	input wire logic [15:0] memWrData,
	input wire logic memWrEn,
	input wire logic burstClk,
	input wire logic chipEnN,
	input wire logic outEnN,
	input wire logic busWide,
	input wire logic [AW:0] hostAddr,
	output logic [15:0] dataOut_q,
	output logic dataOutEn_q,
	output logic burstActive_q
);
	if (AW < 2 || AW > 20) begin : gAwRange
		// Address counter and memory depth assume this span
		$error("AW out of range");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] syncA_q, syncA_d;
	logic [3:0] syncB_q, syncB_d;
	logic [AW:0] addrA_q, addrB_q;
	logic clkPrev_q, clkPrev_d;
	brc_pins_t pins;

	always_comb begin
		syncA_d = {burstClk, chipEnN, outEnN, busWide};
		syncB_d = syncA_q;
		clkPrev_d = syncB_q[3];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			syncA_q <= 4'h0;
			syncB_q <= 4'h0;
			clkPrev_q <= 1'b0;
			addrA_q <= '0;
			addrB_q <= '0;
		end else begin
			syncA_q <= syncA_d;
			syncB_q <= syncB_d;
			clkPrev_q <= clkPrev_d;
			addrA_q <= hostAddr;
			addrB_q <= addrA_q;
		end
	end

	assign pins = brc_pins_t'(syncB_q[2:0]);

	// ****************************************
	// Configuration register
	// ****************************************
	logic [15:0] cfgRaw_q, cfgRaw_d;
	logic [15:0] rdData_d;
	brc_cfg_t cfg;

	function automatic logic hitCfg(input logic [15:0] a);
		return a == BRC_CFG_OFFSET;
	endfunction : hitCfg

	always_comb begin
		cfgRaw_d = cfgRaw_q;
		rdData_d = 16'h0000;
		if (regWr && hitCfg(regAddr)) begin
			cfgRaw_d = regWrData & BRC_CFG_WMASK;
		end
		if (regRd && hitCfg(regAddr)) begin
			rdData_d = cfgRaw_q & BRC_CFG_WMASK;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfgRaw_q <= BRC_CFG_RESET;
			regRdData_q <= 16'h0000;
		end else begin
			cfgRaw_q <= cfgRaw_d;
			regRdData_q <= rdData_d;
		end
	end

	assign cfg = brc_cfg_t'(cfgRaw_q);

	// ****************************************
	// Link clock edges
	// ****************************************
	logic riseEdge, fallEdge, sampleEdge, stepEdge;

	// Same edge choice for sampling and for stepping the burst
	function automatic logic pickEdge(input logic inv, input logic r, input logic f);
		return inv ? f : r;
	endfunction : pickEdge

	always_comb begin
		riseEdge = syncB_q[3] && !clkPrev_q;
		fallEdge = !syncB_q[3] && clkPrev_q;
		// Invert mode steps on falling edges, so the whole burst moves half a clock
		stepEdge = pickEdge(cfg.sampleEdgeInvert, riseEdge, fallEdge);
		// Disabled: clock not looked at, so floating is harmless
		sampleEdge = cfg.burstEnable && stepEdge;
	end

	// ****************************************
	// Burst engine
	// ****************************************
	brc_state_t state_q, state_d;
	logic [4:0] latCnt_q, latCnt_d;
	logic [10:0] unitCnt_q, unitCnt_d;
	logic holdPh_q, holdPh_d;
	logic [AW:0] addr_q, addr_d;
	logic wide_q, wide_d;
	logic [15:0] dOut_d;
	logic dEn_d, act_d;
	logic [AW-1:0] memRdAddr;
	logic [15:0] memRd;
	logic enablesOn;
	logic [10:0] burstUnits;

	function automatic logic [10:0] unitsFor(input logic [3:0] len, input logic hold);
		if (!hold) begin
			return 11'(11'h001 << len);
		end
		// Length zero with hold would be half a unit; one unit is the least we give
		return (len == 4'h0) ? 11'h001 : 11'(11'h001 << (len - 4'h1));
	endfunction : unitsFor

	// Latency counts selected edges, so inverted mode keeps the same clock count
	always_comb begin
		enablesOn = !pins.chipEnN && !pins.outEnN;
		burstUnits = unitsFor(cfg.burstLength, cfg.hold);
	end

	always_comb begin
		state_d = state_q;
		latCnt_d = latCnt_q;
		unitCnt_d = unitCnt_q;
		holdPh_d = holdPh_q;
		addr_d = addr_q;
		wide_d = wide_q;
		case (state_q)
			BRC_IDLE: begin
				if (sampleEdge && enablesOn) begin
					addr_d = addrB_q;
					wide_d = pins.busWide;
					latCnt_d = 5'(BRC_LAT_BASE) + 5'(cfg.latency) - 5'h01;
					unitCnt_d = burstUnits;
					holdPh_d = 1'b0;
					state_d = BRC_LAT;
				end
			end
			BRC_LAT: begin
				if (!enablesOn) begin
					state_d = BRC_IDLE;
				end else if (stepEdge) begin
					if (latCnt_q == 5'h01) begin
						state_d = BRC_DATA;
					end else begin
						latCnt_d = latCnt_q - 5'h01;
					end
				end
			end
			BRC_DATA: begin
				if (!enablesOn) begin
					state_d = BRC_IDLE;
				end else if (stepEdge) begin
					if (cfg.hold && !holdPh_q) begin
						holdPh_d = 1'b1;
					end else begin
						holdPh_d = 1'b0;
						addr_d = addr_q + (wide_q ? (AW+1)'(2) : (AW+1)'(1));
						unitCnt_d = unitCnt_q - 11'h001;
						if (unitCnt_q == 11'h001) begin
							state_d = BRC_DONE;
						end
					end
				end
			end
			BRC_DONE: begin
				if (!enablesOn) begin
					state_d = BRC_IDLE;
				end
			end
			default: begin
				state_d = BRC_IDLE;
			end
		endcase
		if (!cfg.burstEnable) begin
			state_d = BRC_IDLE;
		end
	end

	assign memRdAddr = addr_q[AW:1];

	brc_mem #(
		.AW(AW),
		.DW(16)
	) uMem (
		.mclk(mclk),
		.wrAddr(memWrAddr),
		.wrData(memWrData),
		.wrEn(memWrEn),
		.rdAddr(memRdAddr),
		.rdData_q(memRd)
	);

	// ****************************************
	// Byte lane tracking
	// ****************************************
	// Lane must follow the memory's one-cycle read lag, else a byte flickers
	logic laneSel_q, laneSel_d;

	always_comb begin
		laneSel_d = addr_q[0];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			laneSel_q <= 1'b0;
		end else begin
			laneSel_q <= laneSel_d;
		end
	end

	// ****************************************
	// Data output
	// ****************************************
	always_comb begin
		act_d = (state_q != BRC_IDLE);
		dEn_d = (state_q == BRC_DATA);
		if (wide_q) begin
			dOut_d = memRd;
		end else begin
			dOut_d = {8'h00, laneSel_q ? memRd[15:8] : memRd[7:0]};
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= BRC_IDLE;
			latCnt_q <= 5'h00;
			unitCnt_q <= 11'h000;
			holdPh_q <= 1'b0;
			addr_q <= '0;
			wide_q <= 1'b0;
			dataOut_q <= 16'h0000;
			dataOutEn_q <= 1'b0;
			burstActive_q <= 1'b0;
		end else begin
			state_q <= state_d;
			latCnt_q <= latCnt_d;
			unitCnt_q <= unitCnt_d;
			holdPh_q <= holdPh_d;
			addr_q <= addr_d;
			wide_q <= wide_d;
			dataOut_q <= dOut_d;
			dataOutEn_q <= dEn_d;
			burstActive_q <= act_d;
		end
	end
endmodule : brc_burst_read_control

//--- verification/brc_chk.sv
`timescale 1ns/10ps
// ****
// Port checks
// ****
module brc_chk
	import brc_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdData_q,
	input wire logic chipEnN,
	input wire logic busWide,
	input wire logic [15:0] dataOut_q,
	input wire logic dataOutEn_q,
	input wire logic burstActive_q
);
	logic [15:0] cfg_q;
	logic sel;
	assign sel = regAddr == BRC_CFG_OFFSET;
	// Shadow copy, so mode checks need no peek inside
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			cfg_q <= BRC_CFG_RESET;
		else if (regWr && sel)
			cfg_q <= regWrData & BRC_CFG_WMASK;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_rd_unmapped: assert property (regRd && !sel |=> regRdData_q == 16'h0000)
		else $error("unmapped read");
	chk_rd_back: assert property (regRd && sel |=> regRdData_q == $past(cfg_q))
		else $error("readback");
	chk_rd_quiet: assert property (!$past(regRd) |-> regRdData_q == 16'h0000)
		else $error("stray read data");
	chk_off_idle: assert property (!cfg_q[0] [*4] |-> !burstActive_q)
		else $error("burst while off");
	chk_abort_idle: assert property (chipEnN [*8] |-> !dataOutEn_q)
		else $error("drive while deselected");
	chk_byte_hi: assert property (!busWide [*4] ##0 dataOutEn_q |-> dataOut_q[15:8] == 8'h00)
		else $error("byte upper lane");
	chk_first_lat: assert property ($rose(dataOutEn_q) |-> $past(burstActive_q, 4))
		else $error("first word early");
	chk_word_hold: assert property (dataOutEn_q && $changed(dataOut_q) |=> (!dataOutEn_q || $stable(dataOut_q)) [*3])
		else $error("word too short");
	cov_burst: cover property ($rose(burstActive_q));
	cov_bytes: cover property (!busWide && dataOutEn_q);
	cov_back: cover property (regRd && sel ##1 regRdData_q != 16'h0000);
endmodule : brc_chk

bind brc_burst_read_control brc_chk u_chk (.mclk, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q,
	.chipEnN, .busWide, .dataOut_q, .dataOutEn_q, .burstActive_q);

//--- verification/brc_host.sv
`timescale 1ns/10ps
// ****
// Host memory controller
// ****
module brc_host
	import brc_pkg::*;
(
	output logic burstClk,
	output logic chipEnN,
	output logic outEnN,
	output logic [12:0] hostAddr
);
	initial begin
		burstClk = 1'b0;
		{chipEnN, outEnN} = 2'b11;
		hostAddr = 13'h0000;
		#13;
		forever #(BRC_LINK_NS / 2) burstClk = ~burstClk;
	end
	task automatic burst(input logic [12:0] a, input int n);
		@(posedge burstClk) hostAddr = a;
		@(posedge burstClk) #(BRC_LINK_NS / 4);
		{chipEnN, outEnN} = 2'b00;
		repeat (n) @(posedge burstClk);
		{chipEnN, outEnN} = 2'b11;
		hostAddr = ~a; // Released bus is not left at the last value
	endtask : burst
endmodule : brc_host

//--- verification/tb_burst_read_control.sv
`timescale 1ns/10ps
// ****
// Bench
// ****
module tb_burst_read_control
	import brc_pkg::*;
;
	logic mclk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, memWrEn = 1'b0, busWide = 1'b0;
	logic [15:0] regAddr = '0, regWrData = '0, memWrData = '0, regRdData_q, dataOut_q, prev;
	logic [11:0] memWrAddr = '0;
	logic burstClk, chipEnN, outEnN, dataOutEn_q, burstActive_q, act;
	logic [12:0] hostAddr;
	logic [15:0] q[$];
	int miscompares = 0, n_checks = 0, cyc = 0, t0, lat, latA, stab, enCyc;
	brc_burst_read_control u_dut (.mclk, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q, .memWrAddr,
		.memWrData, .memWrEn, .burstClk, .chipEnN, .outEnN, .busWide, .hostAddr, .dataOut_q, .dataOutEn_q, .burstActive_q);
	brc_host u_host (.burstClk, .chipEnN, .outEnN, .hostAddr);
	always #(BRC_CLK_NS / 2) mclk = ~mclk;
	// Keep a word only once it has settled, sync lag makes short glitches
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		act <= act | burstActive_q;
		enCyc <= enCyc + dataOutEn_q;
		if ($fell(chipEnN))
			t0 <= cyc;
		if ($rose(dataOutEn_q))
			lat <= cyc - t0;
		stab <= (dataOutEn_q && dataOut_q === prev) ? stab + 1 : 0;
		prev <= dataOut_q;
		if (dataOutEn_q && stab == 3)
			q.push_back(dataOut_q);
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk) {regWr, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge mclk) regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge mclk) {regRd, regAddr} <= {1'b1, a};
		@(posedge mclk) regRd <= 1'b0;
		@(negedge mclk) check(regRdData_q, exp);
	endtask : rd
	task automatic t_regs();
		rd(BRC_CFG_OFFSET, 16'h0000);
		wr(BRC_CFG_OFFSET, 16'hFFFF);
		rd(BRC_CFG_OFFSET, 16'hFF07);
		wr(16'h101E, 16'h0000);
		rd(16'h101E, 16'h0000);
		rd(BRC_CFG_OFFSET, 16'hFF07);
		wr(BRC_CFG_OFFSET, 16'h0000);
	endtask : t_regs
	task automatic t_off();
		act = 1'b0;
		u_host.burst(13'h0010, 12);
		check({15'h0000, act}, 16'h0000);
	endtask : t_off
	task automatic t_burst(input logic [15:0] cfg, input logic [12:0] a, input int n, input logic wide);
		logic [12:0] b;
		logic [7:0] w;
		@(posedge mclk) busWide <= wide;
		wr(BRC_CFG_OFFSET, cfg);
		q.delete();
		enCyc = 0;
		u_host.burst(a, 16 + 2 * n);
		check(16'(q.size()), 16'(n));
		check(16'((enCyc + 4) / 8), 16'(n * (cfg[2] + 1)));
		foreach (q[k]) begin
			b = a + (wide ? 2 * k : k);
			w = b[8:1];
			check(q[k], wide ? {8'h80 | w, w} : {8'h00, b[0] ? 8'h80 | w : w});
		end
	endtask : t_burst
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 128; i++) begin
			@(posedge mclk) {memWrEn, memWrAddr, memWrData} <= {1'b1, 12'(i), 8'h80 | 8'(i), 8'(i)};
		end
		@(posedge mclk) memWrEn <= 1'b0;
		t_regs();
		t_off();
		t_burst(16'h2001, 13'h0010, 4, 1'b1);
		latA = lat;
		t_burst(16'h3201, 13'h0020, 8, 1'b1);
		check(16'(lat - latA), 16'h0010);
		t_burst(16'h2207, 13'h0005, 2, 1'b0);
		t_burst(16'h0005, 13'h0030, 1, 1'b1);
		tally_and_finish();
	end
endmodule : tb_burst_read_control
